// ---- rtl/gtimer_pkg.sv ----
// Package: register map, field layout, modes and carriers of the general timer
package gtimer_pkg;

	// ****************************************************************
	// Register offsets (byte addresses on the APB)
	// ****************************************************************
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] MODE_OFFSET = 8'h04;
	localparam logic [7:0] TIMER_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0c;
	localparam logic [7:0] COUNT_OFFSET = 8'h10;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_START_BIT = 0;
	localparam int MODE_SEL_LSB = 0;
	localparam int MODE_SRC_LSB = 2;
	localparam int MODE_EVT_LSB = 4;
	localparam int MODE_MEAS_LSB = 6;
	localparam int STATUS_IRQ_BIT = 0;
	localparam int STATUS_OVF_BIT = 1;
	localparam int STATUS_VALID_BIT = 2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] TIMER_RESET = 16'h0000;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic OVF_RESET = 1'b1;

	// ****************************************************************
	// Timing counts
	// ****************************************************************
	localparam int DIV_EIGHT = 8;
	localparam int DIV_THIRTYTWO = 32;
	localparam logic [4:0] PRESCALE_MAX = 5'h1f;

	typedef enum logic [1:0] {
		MODE_TIMER,
		MODE_EVENT,
		MODE_MEASURE,
		MODE_RSVD
	} op_mode_t;

	typedef enum logic [1:0] {
		SRC_DIV_ONE,
		SRC_DIV_EIGHT,
		SRC_DIV_THIRTYTWO,
		SRC_SEC_DIV_THIRTYTWO
	} src_sel_t;

	typedef enum logic [1:0] {
		EVT_FALL,
		EVT_RISE,
		EVT_BOTH,
		EVT_NEIGHBOUR
	} evt_sel_t;

	typedef enum logic [1:0] {
		MEAS_PERIOD_FALL,
		MEAS_PERIOD_RISE,
		MEAS_WIDTH,
		MEAS_RSVD
	} meas_sel_t;

	typedef struct packed {
		meas_sel_t meas;
		evt_sel_t evt;
		src_sel_t src;
		op_mode_t mode;
	} mode_reg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

// ---- rtl/edge_sampler.sv ----
// Edge sampler: registers a pin and reports its rising and falling edges
`timescale 1ns/10ps
module edge_sampler (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic level_i,
	output logic rise_o,
	output logic fall_o
);
	logic last_q;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			last_q <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
		end else begin
			last_q <= level_i;
			rise_o <= level_i & ~last_q;
			fall_o <= ~level_i & last_q;
		end
	end
endmodule // edge_sampler

// ---- rtl/general_timer_with_pulse_measure.sv ----
// General 16-bit timer with event counting and pulse measurement, APB slave
// Functional notes
// - One 16-bit counter in timer, event counter or measurement mode.
// - Internal source is main clock divided by 1, 8 or 32.
// - Fourth internal source is secondary clock divided by 32.
// - Timer and event modes divide by loaded value plus one, then interrupt.
// - Timer register reads return live count; access as one 16-bit transfer.
// - Measurement read undefined until second edge, then latest result.
// - Write while running updates only the reload register.
// - Write while stopped loads both reload register and counter.
// - Timer register writes ignored in measurement modes.
// - Timer mode decrements once per enabled internal source pulse.
// - Timer mode underflow reloads, continues and sets interrupt request.
// - Clearing start freezes counter in timer and event modes.
// - Event source: falling, rising, both edges or neighbour overflow.
// - Event mode decrements per event; underflow reloads and requests.
// - Measurement: fall-to-fall period, rise-to-rise period, or width.
// - First edge after start clears counter, no interrupt request.
// - Later edges copy counter to reload, request, then clear counter.
// - Request on edge or overflow; overflow flag tells them apart.
// - Mode write while started clears overflow flag; software cannot set it.
// - Counter undefined at measure start; overflow may set at once.
// - Width mode measures high and low widths alternately.
// - Reset sets the overflow flag.
// - Changing measurement selection after start sets interrupt request.
`timescale 1ns/10ps
module general_timer_with_pulse_measure
	import gtimer_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic secondary_clock_div_thirtytwo_i,
	input wire logic event_input_pin_i,
	input wire logic neighbour_timer_overflow_i,
	output logic irq_request_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic start;
		mode_reg_t mode;
		logic [15:0] reload;
		logic [15:0] count;
		logic irq;
		logic ovf;
		logic [1:0] edges_seen;
		logic [4:0] prescale;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} state_t;

	state_t state_q;
	state_t state_d;
	apb_req_t req;
	logic pin_rise;
	logic pin_fall;
	logic sec_rise;
	logic sec_fall;
	logic [4:0] sec_div_q;
	logic [4:0] sec_div_d;
	logic src_tick;
	logic evt_tick;
	logic meas_edge;
	logic access;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
	assign access = req.psel & req.penable & ~state_q.ready;

	edge_sampler pin_sampler (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.level_i(event_input_pin_i),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	edge_sampler sec_sampler (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.level_i(secondary_clock_div_thirtytwo_i),
		.rise_o(sec_rise),
		.fall_o(sec_fall)
	);

	// ****************************************************************
	// Decoding
	// ****************************************************************
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
		addr_is = (a == off);
	endfunction

	function automatic logic meas_hit(input meas_sel_t m, input logic r, input logic f);
		case (m)
			MEAS_PERIOD_FALL: meas_hit = f;
			MEAS_PERIOD_RISE: meas_hit = r;
			MEAS_WIDTH: meas_hit = r | f;
			default: meas_hit = 1'b0;
		endcase
	endfunction

	// Secondary clock pulses, divided by 32 in the clock domain of the core
	always_comb begin
		sec_div_d = sec_div_q;
		if (sec_rise) begin
			sec_div_d = sec_div_q + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sec_div_q <= 5'h00;
		end else begin
			sec_div_q <= sec_div_d;
		end
	end

	// Internal count source select
	always_comb begin
		case (state_q.mode.src)
			SRC_DIV_ONE: src_tick = 1'b1;
			SRC_DIV_EIGHT: src_tick = (state_q.prescale[2:0] == 3'h7);
			SRC_DIV_THIRTYTWO: src_tick = (state_q.prescale == PRESCALE_MAX);
			SRC_SEC_DIV_THIRTYTWO: src_tick = sec_rise & (sec_div_q == PRESCALE_MAX);
			default: src_tick = 1'b0;
		endcase
	end

	// Event source select
	always_comb begin
		case (state_q.mode.evt)
			EVT_FALL: evt_tick = pin_fall;
			EVT_RISE: evt_tick = pin_rise;
			EVT_BOTH: evt_tick = pin_rise | pin_fall;
			EVT_NEIGHBOUR: evt_tick = neighbour_timer_overflow_i;
			default: evt_tick = 1'b0;
		endcase
	end

	assign meas_edge = meas_hit(state_q.mode.meas, pin_rise, pin_fall);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic set_irq;
		logic tick;
		logic [15:0] wdata;
		mode_reg_t new_mode;
		set_irq = 1'b0;
		tick = 1'b0;
		wdata = req.pwdata[15:0];
		new_mode = mode_reg_t'(req.pwdata[7:0]);
		state_d = state_q;
		state_d.ready = 1'b0;
		state_d.slverr = 1'b0;
		state_d.prescale = state_q.prescale + 5'h01;
		if (state_q.mode.mode == MODE_EVENT) begin
			tick = evt_tick;
		end else begin
			tick = src_tick;
		end

		// Counting engine
		if (state_q.start) begin
			case (state_q.mode.mode)
				MODE_TIMER, MODE_EVENT: begin
					if (tick) begin
						if (state_q.count == 16'h0000) begin
							// Divide by reload plus one
							state_d.count = state_q.reload;
							set_irq = 1'b1;
						end else begin
							state_d.count = state_q.count - 16'h0001;
						end
					end
				end
				MODE_MEASURE: begin
					if (meas_edge) begin
						state_d.count = 16'h0000;
						state_d.reload = state_q.count;
						if (state_q.edges_seen != 2'h0) begin
							set_irq = 1'b1;
						end
						if (state_q.edges_seen != 2'h2) begin
							state_d.edges_seen = state_q.edges_seen + 2'h1;
						end
					end else if (tick) begin
						state_d.count = state_q.count + 16'h0001;
						if (state_q.count == 16'hffff) begin
							// Counter starts undefined so this may fire early
							state_d.ovf = 1'b1;
							set_irq = 1'b1;
						end
					end
				end
				default: begin
					state_d.count = state_q.count;
				end
			endcase
		end
		// When start is low the counter simply holds

		// Register access
		state_d.rdata = 32'h0000_0000;
		if (access) begin
			state_d.ready = 1'b1;
			if (req.pwrite) begin
				if (addr_is(req.paddr, CTRL_OFFSET)) begin
					state_d.start = req.pwdata[CTRL_START_BIT];
					if (req.pwdata[CTRL_START_BIT] & ~state_q.start) begin
						state_d.edges_seen = 2'h0;
					end
				end else if (addr_is(req.paddr, MODE_OFFSET)) begin
					state_d.mode = new_mode;
					if (state_q.start) begin
						state_d.ovf = 1'b0;
						if (new_mode.meas != state_q.mode.meas) begin
							set_irq = 1'b1;
						end
					end
				end else if (addr_is(req.paddr, TIMER_OFFSET)) begin
					if (state_q.mode.mode != MODE_MEASURE) begin
						state_d.reload = wdata;
						if (!state_q.start) begin
							state_d.count = wdata;
						end
					end
				end else if (addr_is(req.paddr, STATUS_OFFSET)) begin
					// Writing zero clears; ones do nothing
					if (!req.pwdata[STATUS_IRQ_BIT]) begin
						state_d.irq = 1'b0;
					end
				end else if (!addr_is(req.paddr, COUNT_OFFSET)) begin
					state_d.slverr = 1'b1;
				end
			end else begin
				if (addr_is(req.paddr, CTRL_OFFSET)) begin
					state_d.rdata[CTRL_START_BIT] = state_q.start;
				end else if (addr_is(req.paddr, MODE_OFFSET)) begin
					state_d.rdata[7:0] = state_q.mode;
				end else if (addr_is(req.paddr, TIMER_OFFSET)) begin
					if (state_q.mode.mode == MODE_MEASURE) begin
						state_d.rdata[15:0] = state_q.reload;
					end else begin
						state_d.rdata[15:0] = state_q.count;
					end
				end else if (addr_is(req.paddr, STATUS_OFFSET)) begin
					state_d.rdata[STATUS_IRQ_BIT] = state_q.irq;
					state_d.rdata[STATUS_OVF_BIT] = state_q.ovf;
					state_d.rdata[STATUS_VALID_BIT] = (state_q.edges_seen == 2'h2);
				end else if (addr_is(req.paddr, COUNT_OFFSET)) begin
					state_d.rdata[15:0] = state_q.count;
				end else begin
					state_d.slverr = 1'b1;
				end
			end
		end

		// Hardware set wins over a software clear in the same cycle
		if (set_irq) begin
			state_d.irq = 1'b1;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_q <= '0;
			state_q.mode <= mode_reg_t'(MODE_RESET);
			state_q.reload <= TIMER_RESET;
			state_q.count <= TIMER_RESET;
			state_q.ovf <= OVF_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign prdata = state_q.rdata;
	assign pready = state_q.ready;
	assign pslverr = state_q.slverr;
	assign irq_request_o = state_q.irq;

endmodule // general_timer_with_pulse_measure

// ---- verification/gtimer_chk.sv ----
// Checker: bus answer and interrupt request properties of the general timer
`timescale 1ns/10ps
module gtimer_chk
	import gtimer_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq_request_o
);
	logic acc;
	logic clr;
	// Access phase edge at which the slave takes the request
	assign acc = psel && penable && !pready;
	assign clr = acc && pwrite && paddr == STATUS_OFFSET && !pwdata[STATUS_IRQ_BIT];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_ready_after_take: assert property (acc |=> pready)
		else $error("ready missing after access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_has_cause: assert property (pready |-> $past(acc))
		else $error("ready without access");
	a_err_unmapped: assert property (acc && paddr > COUNT_OFFSET |=> pslverr)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (acc && paddr == TIMER_OFFSET |=> !pslverr)
		else $error("mapped access refused");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_timer_width: assert property (acc && !pwrite && paddr == TIMER_OFFSET
		|=> prdata[31:16] == 16'h0000)
		else $error("timer read wider than sixteen bits");
	a_irq_sticky: assert property (irq_request_o && !clr |=> irq_request_o)
		else $error("request dropped without clear");
endmodule // gtimer_chk

bind general_timer_with_pulse_measure gtimer_chk u_chk (.clk_i, .reset_n_i, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_request_o);

// ---- verification/pulse_partner.sv ----
// Partner: measured pin, neighbour overflow pulses and secondary clock
`timescale 1ns/10ps
module pulse_partner (
	input wire logic clk_i,
	output logic pin_o,
	output logic ovf_o,
	output logic sec_o
);
	logic [1:0] sec_q;
	initial begin
		pin_o = 1'b0;
		ovf_o = 1'b0;
		sec_q = 2'h0;
	end
	// Secondary clock runs free at a quarter of the main rate
	always @(posedge clk_i) begin
		sec_q <= sec_q + 2'h1;
	end
	assign sec_o = sec_q[1];
	// Pin is only driven once its port counts as an input
	task automatic drive(input logic lvl, input int n);
		@(posedge clk_i);
		pin_o <= lvl;
		repeat (n - 1) @(posedge clk_i);
	endtask
	task automatic blip();
		@(posedge clk_i);
		ovf_o <= 1'b1;
		@(posedge clk_i);
		ovf_o <= 1'b0;
	endtask
endmodule // pulse_partner

// ---- verification/tb.sv ----
// Testbench: register-level tests of the general timer
`timescale 1ns/10ps
module tb;
	import gtimer_pkg::*;
	logic clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, er, irq, pin, novf, sec;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] v0;
	int errors, cmp_count;
	int nrd[4] = '{1, 8, 8, 32};
	int dif[4] = '{4, 4, 1, 1};
	int evx[4] = '{1, 1, 8, 1};
	int msx[3] = '{11, 11, 4};
	general_timer_with_pulse_measure u_dut (.clk_i, .reset_n_i, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .secondary_clock_div_thirtytwo_i(sec),
		.event_input_pin_i(pin), .neighbour_timer_overflow_i(novf), .irq_request_o(irq));
	pulse_partner u_src (.clk_i, .pin_o(pin), .ovf_o(novf), .sec_o(sec));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, pready, 1'b1);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic give_verdict();
		if (errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		errors++;
		give_verdict();
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		{reset_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
		errors = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rdc(STATUS_OFFSET, 32'h2);
		rdc(8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		for (int s = 0; s < 4; s++) begin
			wr(MODE_OFFSET, {28'h0, 2'(s), 2'b00});
			wr(TIMER_OFFSET, 32'h1000);
			rdc(COUNT_OFFSET, 32'h1000);
			wr(CTRL_OFFSET, 32'h1);
			bus(1'b0, COUNT_OFFSET, 32'h0);
			v0 = rd[15:0];
			repeat (nrd[s]) bus(1'b0, COUNT_OFFSET, 32'h0);
			v0 = v0 - rd[15:0];
			chk({16'h0, v0}, dif[s]);
			wr(CTRL_OFFSET, 32'h0);
			bus(1'b0, TIMER_OFFSET, 32'h0);
			v0 = rd[15:0];
			repeat (40) @(posedge clk_i);
			rdc(TIMER_OFFSET, {16'h0, v0});
		end
		wr(MODE_OFFSET, 32'h0);
		wr(TIMER_OFFSET, 32'h5);
		wr(STATUS_OFFSET, 32'h0);
		wr(CTRL_OFFSET, 32'h1);
		bus(1'b0, COUNT_OFFSET, 32'h0);
		repeat (6) begin
			v0 = rd[15:0];
			rdc(COUNT_OFFSET, (v0 + 32'h2) % 6);
		end
		wr(CTRL_OFFSET, 32'h0);
		repeat (2) rdc(STATUS_OFFSET, 32'h3);
		wr(STATUS_OFFSET, 32'h0);
		rdc(STATUS_OFFSET, 32'h2);
		for (int s = 0; s < 4; s++) begin
			wr(MODE_OFFSET, {26'h0, 2'(s), 4'h1});
			wr(TIMER_OFFSET, 32'h4);
			wr(STATUS_OFFSET, 32'h0);
			wr(CTRL_OFFSET, 32'h1);
			wr(TIMER_OFFSET, 32'h9);
			rdc(COUNT_OFFSET, 32'h4);
			repeat (3) begin
				u_src.drive(1'b1, 3);
				u_src.drive(1'b0, 3);
				if (s == 3) u_src.blip();
			end
			wr(CTRL_OFFSET, 32'h0);
			rdc(COUNT_OFFSET, evx[s]);
			chk({31'h0, irq}, {31'h0, s == 2});
		end
		for (int m = 0; m < 3; m++) begin
			wr(MODE_OFFSET, {24'h0, 2'(m), 6'h02});
			wr(CTRL_OFFSET, 32'h1);
			wr(MODE_OFFSET, {24'h0, 2'(m), 6'h02});
			wr(STATUS_OFFSET, 32'h0);
			u_src.drive(1'b1, 5);
			u_src.drive(1'b0, 7);
			if (m < 2) chk({31'h0, irq}, 32'h0);
			u_src.drive(1'b1, 5);
			u_src.drive(1'b0, 7);
			rdc(TIMER_OFFSET, msx[m]);
			rdc(STATUS_OFFSET, 32'h5);
			wr(TIMER_OFFSET, 32'h1234);
			rdc(TIMER_OFFSET, msx[m]);
			wr(CTRL_OFFSET, 32'h0);
		end
		// Measurement counter wraps past its maximum: overflow flag and request
		wr(MODE_OFFSET, 32'h0);
		wr(TIMER_OFFSET, 32'hfff0);
		wr(MODE_OFFSET, 32'h2);
		wr(STATUS_OFFSET, 32'h0);
		wr(CTRL_OFFSET, 32'h1);
		repeat (20) @(posedge clk_i);
		rdc(STATUS_OFFSET, 32'h3);
		wr(STATUS_OFFSET, 32'h0);
		wr(MODE_OFFSET, 32'h42);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		give_verdict();
	end
endmodule // tb
